//--- comm_err_pkg.sv
/*
 * shared constants for the communication error classifier and its history log.
 * assumes a single clock domain; no software-visible registers.
 */
package comm_err_pkg;
    localparam int CODE_W = 8;
    localparam int HIST_DEPTH = 10;
    localparam logic [7:0] ERR_LINK = 8'h84;
    localparam logic [7:0] ERR_UNDEFINED = 8'h88;
    localparam logic [7:0] ERR_PORT_BUSY = 8'h89;
    localparam logic [7:0] ERR_NVM_BUSY = 8'h8a;
    localparam logic [7:0] ERR_RANGE = 8'h8c;
    localparam logic [7:0] ERR_EXEC_DISABLED = 8'h8d;
    localparam logic [7:0] NO_CODE = 8'h00;
    localparam logic [3:0] HIST_EMPTY = 4'h0;
endpackage

//--- hist_if.sv
/*
 * carrier between the classifier and the history store.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface hist_if;
    logic push;
    logic [7:0] code;
    logic clear;
    logic [3:0] rdIndex;
    logic [7:0] rdCode;
    logic [3:0] count;
    modport ctrl (output push, output code, output clear, output rdIndex,
                  input rdCode, input count);
    modport store (input push, input code, input clear, input rdIndex,
                   output rdCode, output count);
endinterface

//--- err_history.sv
/*
 * newest-first history of communication error codes held in volatile storage.
 * assumes push and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
module err_history #(
    parameter int DEPTH = comm_err_pkg::HIST_DEPTH
) (
    input wire logic clk,     // system clock
    input wire logic arst_n,  // async reset, active low
    hist_if.store hist        // push, clear and read port
);
    logic [7:0] entries [DEPTH];
    logic [3:0] count;

    // shift register: entry 0 is always the newest; oldest drops off the end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                entries[i] <= comm_err_pkg::NO_CODE;
            end
        end else if (hist.push) begin
            entries[0] <= hist.code;
            for (int i = 1; i < DEPTH; i++) begin
                entries[i] <= entries[i-1];
            end
        end else if (hist.clear) begin
            for (int i = 0; i < DEPTH; i++) begin
                entries[i] <= comm_err_pkg::NO_CODE;
            end
        end
    end

    // valid-entry count; a push in the clear cycle wins so the event is kept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= comm_err_pkg::HIST_EMPTY;
        end else if (hist.push && hist.clear) begin
            count <= 4'h1;
        end else if (hist.push) begin
            if (count < 4'(DEPTH)) begin
                count <= count + 4'h1;
            end
        end else if (hist.clear) begin
            count <= comm_err_pkg::HIST_EMPTY;
        end
    end

    // reads past the held entries show zero
    assign hist.rdCode = (hist.rdIndex < count) ? entries[hist.rdIndex] : comm_err_pkg::NO_CODE;
    assign hist.count = count;
endmodule

//--- comm_error_classifier_log.sv
/*
 * classifies why a master request is refused and logs the error code.
 * assumes request and status inputs come from logic on the same clock;
 * the frame decoder upstream flags link errors and undefined commands.
 */
`timescale 1ns/1ps
// Overview of operation
// - undefined command code is refused and logged as 88h
// - command refused with 89h while operator tool port is communicating
// - nvm processing, internal busy or nvm alarm refuses command with 8Ah
// - out-of-range setting data is not applied and 8Ch is logged
// - command not allowed in current state is refused with 8Dh
// - history holds up to ten codes, newest first, volatile
// - monitor read returns logged codes newest first
// - maintenance clear empties the history; an error logged in the same cycle stays as the only entry
// - history is empty after power-up or reset
// - framing or check-character error logs 84h
module comm_error_classifier_log #(
    parameter int DEPTH = comm_err_pkg::HIST_DEPTH
) (
    input wire logic clk,                      // 200 MHz system clock
    input wire logic arst_n,                   // async reset, active low
    input wire logic frameError,               // pulse: framing or check error seen
    input wire logic reqValid,                 // pulse: decoded request from master
    input wire logic cmdDefined,               // request's command code is defined
    input wire logic isWrite,                  // request carries setting data
    input wire logic dataInRange,              // setting data within permitted range
    input wire logic execAllowed,              // device state allows this command
    input wire logic toolPortActive,           // operator tool port is communicating
    input wire logic nvmProcessing,            // non-volatile memory work under way
    input wire logic internal_processing_busy, // internal busy flag
    input wire logic nvmErrorAlarm,            // non-volatile memory error alarm
    output logic reqAccept,                    // pulse: request may be executed
    output logic reqRefuse,                    // pulse: request refused
    output logic [7:0] refuseCode,             // code of last refusal, registered
    input wire logic histClear,                // pulse: maintenance clear command
    input wire logic histRead,                 // pulse: monitor read of one entry
    input wire logic [3:0] histIndex,          // entry to read, 0 is newest
    output logic histReadValid,                // pulse: histReadCode is fresh
    output logic [7:0] histReadCode,           // read entry, zero if unused
    output logic [3:0] histCount               // number of entries held
);
    hist_if hist ();

    logic [7:0] next_code;
    logic refuse;

    // priority order: link error first, then the command checks in code order
    always_comb begin
        next_code = comm_err_pkg::NO_CODE;
        refuse = 1'b0;
        if (reqValid) begin
            refuse = 1'b1;
            if (!cmdDefined) begin
                next_code = comm_err_pkg::ERR_UNDEFINED;
            end else if (toolPortActive) begin
                next_code = comm_err_pkg::ERR_PORT_BUSY;
            end else if (nvmProcessing || internal_processing_busy || nvmErrorAlarm) begin
                next_code = comm_err_pkg::ERR_NVM_BUSY;
            end else if (isWrite && !dataInRange) begin
                next_code = comm_err_pkg::ERR_RANGE;
            end else if (!execAllowed) begin
                next_code = comm_err_pkg::ERR_EXEC_DISABLED;
            end else begin
                refuse = 1'b0;
            end
        end
    end

    // accept only when every check passes, so a refusal never reaches settings
    assign reqAccept = reqValid && !refuse && !frameError;
    assign reqRefuse = reqValid && (refuse || frameError);

    // a corrupt frame overrides any classification of its content
    assign hist.push = frameError || refuse;
    assign hist.code = frameError ? comm_err_pkg::ERR_LINK : next_code;
    assign hist.clear = histClear;
    assign hist.rdIndex = histIndex;

    // last refusal code kept for the response formatter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            refuseCode <= comm_err_pkg::NO_CODE;
        end else if (hist.push) begin
            refuseCode <= hist.code;
        end
    end

    // monitor read answers one cycle later from flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            histReadValid <= 1'b0;
            histReadCode <= comm_err_pkg::NO_CODE;
        end else begin
            histReadValid <= histRead;
            if (histRead) begin
                histReadCode <= hist.rdCode;
            end
        end
    end

    assign histCount = hist.count;

    err_history #(
        .DEPTH(DEPTH)
    ) history (
        .clk(clk),
        .arst_n(arst_n),
        .hist(hist)
    );
endmodule

//--- err_log_checker.sv
/* assertions on the classifier ports.
   assumes one clock domain; bound into the top module. */
`timescale 1ns/1ps
module err_log_checker #(parameter int DEPTH = 10) (
    input wire logic clk, // clock
    input wire logic arst_n, // reset, active low
    input wire logic frameError, // bad frame
    input wire logic reqValid, // request
    input wire logic cmdDefined, // known command
    input wire logic reqAccept, // accepted
    input wire logic reqRefuse, // refused
    input wire logic [7:0] refuseCode, // last code
    input wire logic histClear, // clear
    input wire logic histRead, // read
    input wire logic histReadValid, // read done
    input wire logic [3:0] histCount // entries
);
    // all checks share the one clock and its reset
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_und;
        reqValid && !cmdDefined && !frameError |-> reqRefuse ##1 refuseCode == 8'h88;
    endproperty
    a_und: assert property (p_und) else $error("bad undefined refusal");
    property p_lnk;
        frameError |=> refuseCode == 8'h84;
    endproperty
    a_lnk: assert property (p_lnk) else $error("bad link code");
    property p_max;
        histCount <= DEPTH;
    endproperty
    a_max: assert property (p_max) else $error("count too big");
    property p_clr;
        histClear && !frameError && !reqRefuse |=> histCount == 4'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear failed");
    property p_rd;
        histRead |=> histReadValid;
    endproperty
    a_rd: assert property (p_rd) else $error("no read answer");
    property p_inc;
        reqRefuse && !histClear && histCount < DEPTH |=> histCount == $past(histCount) + 4'h1;
    endproperty
    a_inc: assert property (p_inc) else $error("count not raised");
    property p_full;
        reqRefuse && !histClear && histCount == DEPTH |=> histCount == DEPTH;
    endproperty
    a_full: assert property (p_full) else $error("full count moved");
    property p_acc;
        reqAccept && !frameError && !histClear |=> $stable(histCount) && $stable(refuseCode);
    endproperty
    a_acc: assert property (p_acc) else $error("accept changed log");
    c_ref: cover property (reqRefuse);
    c_full: cover property (histCount == DEPTH);
    c_rd: cover property (histReadValid);
endmodule
bind comm_error_classifier_log err_log_checker #(.DEPTH(DEPTH)) i_chk (.*);

//--- master_model.sv
/* master side: issues requests, monitor reads and clears.
   assumes the device samples on the rising clock edge. */
`timescale 1ns/1ps
module master_model (
    input wire logic clk, // clock
    output logic reqValid, // request pulse
    output logic frameError, // bad frame pulse
    output logic histRead, // monitor read pulse
    output logic histClear, // maintenance clear pulse
    output logic [3:0] histIndex, // entry to read
    output logic [7:0] req // command flags and status levels
);
    // idle from time zero
    initial {reqValid, frameError, histRead, histClear, histIndex, req} = '0;
    // one pulse held a whole cycle, levels kept after
    task automatic op(input logic [3:0] p, input logic [3:0] i, input logic [7:0] f);
        @(posedge clk);
        {reqValid, frameError, histRead, histClear} <= p;
        histIndex <= i;
        req <= f;
        @(posedge clk);
        {reqValid, frameError, histRead, histClear} <= 4'h0;
    endtask
endmodule

//--- comm_error_classifier_log_bench.sv
/* self-checking bench for the error classifier and history.
   assumes the master model drives all request lines. */
`timescale 1ns/1ps
module comm_error_classifier_log_bench;
    logic clk = 0, arst_n = 0, reqValid, frameError, histRead, histClear;
    logic reqAccept, reqRefuse, histReadValid;
    logic [7:0] req, refuseCode, histReadCode;
    logic [3:0] histIndex, histCount;
    int mismatches = 0, num_checks = 0;
    int acceptSeen = 0, refuseSeen = 0;
    // count accept and refuse pulses at the edge where the design takes the request
    always @(posedge clk) begin
        if (reqAccept) acceptSeen++;
        if (reqRefuse) refuseSeen++;
    end
    // flags {cmd, write, range, exec, tool, nvm, busy, alarm}; last one goes with a bad frame
    logic [7:0] fl[8] = '{8'h00, 8'h88, 8'h84, 8'h82, 8'h81, 8'hc0, 8'ha0, 8'hb0};
    logic [7:0] ex[8] = '{8'h88, 8'h89, 8'h8a, 8'h8a, 8'h8a, 8'h8c, 8'h8d, 8'h84};
    always #2.5 clk = ~clk;
    master_model i_master (.*);
    comm_error_classifier_log i_dut (.*, .cmdDefined(req[7]), .isWrite(req[6]),
        .dataInRange(req[5]), .execAllowed(req[4]), .toolPortActive(req[3]),
        .nvmProcessing(req[2]), .internal_processing_busy(req[1]), .nvmErrorAlarm(req[0]));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input int i, input logic [7:0] exp);
        i_master.op(4'h2, 4'(i), 8'hb0);
        #1;
        cmp({7'h0, histReadValid}, 8'h01);
        cmp(histReadCode, exp);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_codes();
        for (int k = 0; k < 8; k++) begin
            i_master.op(k == 7 ? 4'hc : 4'h8, 4'h0, fl[k]);
            #1;
            cmp(refuseCode, ex[k]);
        end
        i_master.op(4'h8, 4'h0, 8'hb0);
        #1;
        cmp(refuseCode, 8'h84);
        cmp({4'h0, histCount}, 8'h08);
        cmp(8'(refuseSeen), 8'h08);
        cmp(8'(acceptSeen), 8'h01);
        $display("codes and accept done");
    endtask
    task automatic t_hist();
        i_master.op(4'h1, 4'h0, 8'hb0);
        #1;
        cmp({4'h0, histCount}, 8'h00);
        for (int k = 0; k < 11; k++)
            i_master.op(k % 8 == 7 ? 4'hc : 4'h8, 4'h0, fl[k % 8]);
        #1;
        cmp({4'h0, histCount}, 8'h0a);
        for (int i = 0; i < 11; i++)
            rd(i, i < 10 ? ex[(10 - i) % 8] : 8'h00);
        $display("history done");
    endtask
    // a reset in mid-run must leave the log empty
    task automatic t_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        #1;
        cmp({4'h0, histCount}, 8'h00);
        cmp(refuseCode, 8'h00);
        rd(0, 8'h00);
        $display("reset done");
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_codes();
        t_hist();
        t_reset();
        end_of_test();
    end
endmodule
